// ### dv/test_upstream_channel_tlv_decoder.sv
// test_upstream_channel_tlv_decoder.sv: self-checking bench of the sender
`timescale 1ns/1ps
module test_upstream_channel_tlv_decoder;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [71:0] ts_snap;
  logic [7:0]  tx_data;
  logic        tx_valid, tx_last, tx_ready;
  logic [7:0]  exp [$];
  int          fail_count, cmp_count;
  // ctrl, frame, burst, expected error bits
  logic [127:0] etab [0:9] = '{
    128'h00000003_00402000_00000101_00000002,
    128'h00000003_00402021_00000101_00000002,
    128'h00000003_00400101_00000101_00000002,
    128'h00000003_00400301_00000101_00000002,
    128'h00000003_00200201_00000101_00000002,
    128'h00000001_00402001_00000305_00000004,
    128'h00000001_00402001_000b0106_00000004,
    128'h00000001_00402001_00000100_00000004,
    128'h00000031_00402001_00000101_00000008,
    128'h0000000d_00402001_00000101_00000008};

  uct_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ts_snap(ts_snap),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready));
  uct_link_model lm (.hclk(hclk), .hresetn(hresetn), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .slow(slow));

  // 100 MHz clock
  always #5 hclk = ~hclk;

  task cmp32(input logic [31:0] got, input logic [31:0] e, input string w);
    cmp_count++;
    if (got !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, w, got, e);
    end
  endtask : cmp32

  task cmp8(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      fail_count++;
      $display("mismatch at %0t: byte got %h exp %h", $time, got, e);
    end
  endtask : cmp8

  // single word transfer; address held until hready, then data phase
  task ahb(input logic [31:0] a, input logic wr, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    st = hrdata;
  endtask : ahb

  // start a message, wait for its last byte and idle, compare stream
  task run_msg(input logic [31:0] ctrl);
    int m;
    int i;
    m = lm.msgs;
    ahb(32'h00, 1'b1, ctrl);
    while (lm.msgs == m) @(posedge hclk);
    do ahb(32'h14, 1'b0, 32'h0); while (st[0] !== 1'b0);
    cmp32({25'h0, lm.cnt}, 32'(exp.size()), "length");
    for (i = 0; i < exp.size(); i++) cmp8(lm.cap[i], exp[i]);
  endtask : run_msg

  task t_regs;
    cmp32({31'h0, hresp}, 32'h0, "hresp");
    ahb(32'h14, 1'b0, 32'h0);
    cmp32(st, 32'h0, "stat reset");
    ahb(32'h04, 1'b1, 32'h00402001);
    ahb(32'h04, 1'b0, 32'h0);
    cmp32(st, 32'h00402001, "frame readback");
    ahb(32'h14, 1'b1, 32'hffffffff);
    ahb(32'h14, 1'b0, 32'h0);
    cmp32(st, 32'h0, "stat read-only");
    ahb(32'h18, 1'b0, 32'h0);
    cmp32(st, 32'h0, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task t_tdma;
    slow <= 1'b1;
    ahb(32'h10, 1'b1, 32'h000a0101);
    exp = '{8'h00, 8'h07, 8'h01, 8'h02, 8'h10, 8'h01, 8'h01, 8'h04,
            8'h07, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h01, 8'h0a};
    run_msg(32'h11);
    cmp32({31'h0, lm.mode_on}, 32'h0, "mode off");
    cmp32({31'h0, lm.psd_on}, 32'h0, "density absent");
    cmp32({31'h0, lm.rng_due}, 32'h1, "ranging due");
    $display("test tdma done");
  endtask : t_tdma

  // code-division message: seed 0x4001 left-justified is 80 02
  task mk_cdma(input logic [7:0] cc);
    int i;
    exp = '{cc, 8'h07, 8'h01, 8'h01, 8'h08, 8'h01, 8'h20, 8'h09, 8'h01,
            8'h02, 8'h0a, 8'h01, 8'h80, 8'h0b, 8'h02, 8'h80, 8'h02,
            8'h0c, 8'h02, 8'h12, 8'h34, 8'h0d, 8'h02, 8'h56, 8'h78,
            8'h0e, 8'h09};
    for (i = 0; i < 9; i++) exp.push_back(ts_snap[71-8*i -: 8]);
    exp = {exp, 8'h0f, 8'h01, 8'h01, 8'h10, 8'h01, 8'h02, 8'h05, 8'h07,
           8'h09, 8'h01, 8'h01, 8'h02, 8'h05, 8'h01, 8'h10};
  endtask : mk_cdma

  task t_cdma;
    slow <= 1'b0;
    ts_snap <= 72'h010203040506070809;
    ahb(32'h04, 1'b1, 32'h00800220);
    ahb(32'h08, 1'b1, 32'h00004001);
    ahb(32'h0c, 1'b1, 32'h56781234);
    ahb(32'h10, 1'b1, 32'h00100209);
    mk_cdma(8'h01);
    run_msg(32'h27);
    cmp32({24'h0, st[15:8]}, 32'h1, "count");
    cmp32({31'h0, lm.mode_on}, 32'h1, "mode on");
    cmp32({31'h0, lm.psd_on}, 32'h1, "density on");
    cmp32({31'h0, lm.rng_due}, 32'h1, "ranging on change");
    $display("test cdma done");
  endtask : t_cdma

  task t_snap;
    slow <= 1'b1;
    ts_snap <= 72'haabbccddeeff001122;
    @(posedge hclk);
    mk_cdma(8'h01);
    run_msg(32'h27);
    cmp32({24'h0, st[15:8]}, 32'h1, "count held");
    cmp32({31'h0, lm.rng_due}, 32'h0, "no ranging on same");
    $display("test snap done");
  endtask : t_snap

  // illegal settings refused with an error bit and no message
  task t_errors;
    int i;
    int m;
    for (i = 0; i < 10; i++) begin
      m = lm.msgs;
      ahb(32'h04, 1'b1, etab[i][95:64]);
      ahb(32'h10, 1'b1, etab[i][63:32]);
      ahb(32'h00, 1'b1, etab[i][127:96]);
      ahb(32'h14, 1'b0, 32'h0);
      cmp32({28'h0, st[3:0]}, etab[i][31:0], "errors");
      cmp32(32'(lm.msgs), 32'(m), "no message");
    end
    $display("test errors done");
  endtask : t_errors

  // density present but off, no ranging, usage code 6 on type 4
  task t_off;
    slow <= 1'b0;
    ahb(32'h10, 1'b1, 32'h000a0206);
    exp = '{8'h02, 8'h07, 8'h01, 8'h02, 8'h0f, 8'h01, 8'h02, 8'h10,
            8'h01, 8'h00, 8'h04, 8'h07, 8'h06, 8'h01, 8'h01, 8'h02,
            8'h05, 8'h01, 8'h0a};
    run_msg(32'h09);
    cmp32({24'h0, st[15:8]}, 32'h2, "count step");
    cmp32({31'h0, lm.psd_on}, 32'h0, "density off");
    cmp32({31'h0, lm.rng_due}, 32'h0, "no ranging");
    $display("test off done");
  endtask : t_off

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ts_snap = 72'h0;
    slow = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_tdma();
    t_cdma();
    t_snap();
    t_errors();
    t_off();
    tally_and_finish();
  end
endmodule : test_upstream_channel_tlv_decoder

// ### dv/uct_link_model.sv
// uct_link_model.sv: modem-side byte sink for the tlv sender
`timescale 1ns/1ps
module uct_link_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // byte stream from the sender
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // stall on every other cycle when high
  input  wire logic       slow
);
  logic [7:0] cap [0:63];
  logic [6:0] cnt;
  logic       fresh;
  logic       ph;
  logic       mode_on;
  int         msgs;
  logic [1:0] fld;
  logic [7:0] typ;
  logic [7:0] rem;
  logic [7:0] cc_seen;
  logic       seen;
  logic       cc_new;
  logic       psd_on;
  logic       rng_due;

  // ready pattern; slow mode stalls half of all cycles
  assign tx_ready = slow ? ph : 1'b1;

  // capture each message whole, restarting after the final byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph      <= 1'b0;
      cnt     <= 7'h00;
      fresh   <= 1'b1;
      msgs    <= 0;
      mode_on <= 1'b0;
      fld     <= 2'h0;
      typ     <= 8'h00;
      rem     <= 8'h00;
      cc_seen <= 8'h00;
      seen    <= 1'b0;
      cc_new  <= 1'b0;
      psd_on  <= 1'b0;
      rng_due <= 1'b0;
    end else begin
      ph <= ~ph;
      if (tx_valid && tx_ready) begin
        cap[fresh ? 7'h00 : cnt] <= tx_data;
        cnt   <= fresh ? 7'h01 : cnt + 7'h01;
        fresh <= tx_last;
        if (tx_last) msgs <= msgs + 1;
        // mode is off until an explicit on value arrives
        if (fresh) mode_on <= 1'b0;
        else if (cnt == 7'h03 && cap[1] == 8'h07)
          mode_on <= (tx_data == 8'h01);
        // tlv walk; a new count marks a changed channel
        if (fresh) begin
          cc_new  <= !seen || (tx_data != cc_seen);
          cc_seen <= tx_data;
          seen    <= 1'b1;
          fld     <= 2'h0;
          psd_on  <= 1'b0; // absent keeps the old power
          rng_due <= 1'b0;
        end else if (fld == 2'h0) begin
          typ <= tx_data;
          fld <= 2'h1;
        end else if (fld == 2'h1) begin
          // every type, known or not, is stepped over by its length
          rem <= tx_data;
          fld <= (tx_data == 8'h00) ? 2'h0 : 2'h2;
        end else begin
          rem <= rem - 8'h01;
          if (rem == 8'h01) fld <= 2'h0;
          // rescale only when on; a ranging response would override
          if (typ == 8'h0f) psd_on <= (tx_data == 8'h01);
          // ranging on a new count only; service ids are kept
          if (typ == 8'h10)
            rng_due <= (tx_data != 8'h00) && cc_new;
        end
      end
    end
  end
endmodule : uct_link_model

// ### rtl/uct_host.sv
// uct_host.sv: headend sender of channel tlvs, steered over ahb-lite
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "uct_params.svh"
module uct_host
  import uct_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // frame-boundary snapshot source
  input  wire logic [71:0] ts_snap,
  // tlv byte stream toward the modem link
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready
);

  uct_st_s st_q;
  uct_st_s st_d;

  // code-division parameters outside their ranges
  function automatic logic cdma_bad(input uct_cfg_s c);
    logic bad;
    bad = 1'b0;
    if (c.cdma) begin
      bad = (c.spi < `UCT_SPI_MIN) || (c.spi > `UCT_CX_MAX);
      bad = bad || (c.cpm < `UCT_CPM_MIN)
                || (c.cpm > `UCT_CX_MAX);
      bad = bad || (c.act < `UCT_ACT_MIN)
                || (c.act > `UCT_ACT_MAX);
      // cpm is nonzero here, so the modulo is safe
      if (!bad)
        bad = (c.act % c.cpm) != 8'h00;
    end
    return bad;
  endfunction : cdma_bad

  // descriptor must be the newer type
  function automatic logic need5(input uct_cfg_s c);
    logic n5;
    n5 = (c.mod > `UCT_MOD4) || (c.fec > `UCT_FEC4);
    n5 = n5 || (c.uc > 4'h6) || (c.uc == 4'h0);
    n5 = n5 || ((c.uc >= 4'h9) && (c.uc <= 4'hb));
    return n5;
  endfunction : need5

  // descriptor that no type may carry
  function automatic logic burst_bad(input uct_cfg_s c);
    logic bad;
    bad = (c.uc == 4'h0) || (c.mod == 3'h0) || (c.mod > `UCT_MOD_MAX);
    bad = bad || (c.fec > `UCT_FEC_MAX);
    // usage codes 5 and 6 cannot be moved to type 5
    bad = bad || (((c.uc == 4'h5) || (c.uc == 4'h6)) && need5(c));
    return bad;
  endfunction : burst_bad

  // reserved encodings of the mode fields
  function automatic logic mode_bad(input uct_cfg_s c);
    return (c.psd == 2'h3) || (c.rng == 2'h3);
  endfunction : mode_bad

  // one byte of the message walk: {enable, byte}
  function automatic logic [8:0] tlv_byte(input logic [5:0] i,
                                          input uct_cfg_s c,
                                          input logic [71:0] ts,
                                          input logic [7:0] cc,
                                          input logic b5);
    logic [7:0]  b;
    logic        e;
    logic [71:0] sh;
    logic [3:0]  k;
    k  = 4'(i - `UCT_SNAP0);
    sh = ts << {k, 3'b000};
    // code-division tlvs only ride along when the mode is on
    e  = ((i >= `UCT_CX_LO) && (i <= `UCT_CX_HI)) ? c.cdma : 1'b1;
    case (i)
      6'h00: b = cc;
      6'h01: b = `UCT_T_MODE;
      6'h02: b = `UCT_LEN1;
      6'h03: b = c.cdma ? `UCT_ON : `UCT_OFF;
      6'h04: b = `UCT_T_SPI;
      6'h05: b = `UCT_LEN1;
      6'h06: b = c.spi;
      6'h07: b = `UCT_T_CPM;
      6'h08: b = `UCT_LEN1;
      6'h09: b = c.cpm;
      6'h0a: b = `UCT_T_ACT;
      6'h0b: b = `UCT_LEN1;
      6'h0c: b = c.act;
      6'h0d: b = `UCT_T_SEED;
      6'h0e: b = `UCT_LEN2;
      6'h0f: b = c.seed[14:7];
      6'h10: b = {c.seed[6:0], 1'b0};
      6'h11: b = `UCT_T_NUM;
      6'h12: b = `UCT_LEN2;
      6'h13: b = c.m[15:8];
      6'h14: b = c.m[7:0];
      6'h15: b = `UCT_T_DEN;
      6'h16: b = `UCT_LEN2;
      6'h17: b = c.n[15:8];
      6'h18: b = c.n[7:0];
      6'h19: b = `UCT_T_SNAP;
      6'h1a: b = `UCT_LEN9;
      6'h24: b = `UCT_T_PSD;
      6'h25: b = `UCT_LEN1;
      6'h26: b = {6'h00, c.psd};
      6'h27: b = `UCT_T_RNG;
      6'h28: b = `UCT_LEN1;
      6'h29: b = {6'h00, c.rng};
      6'h2a: b = b5 ? `UCT_T_BD5 : `UCT_T_BD4;
      6'h2b: b = `UCT_BD_LEN;
      6'h2c: b = {4'h0, c.uc};
      6'h2d: b = `UCT_A_MOD;
      6'h2e: b = `UCT_LEN1;
      6'h2f: b = {5'h00, c.mod};
      6'h30: b = `UCT_A_FEC;
      6'h31: b = `UCT_LEN1;
      6'h32: b = {3'h0, c.fec};
      default: b = sh[71:64];
    endcase
    // density tlv left out when software marks it absent
    if ((i >= 6'h24) && (i <= 6'h26))
      e = |c.psd;
    return {e, b};
  endfunction : tlv_byte

  // register read view
  function automatic logic [31:0] reg_rd(input logic [7:0] a,
                                         input uct_st_s s);
    logic [31:0] r;
    case (a)
      `UCT_A_CTRL:
        r = {26'h0, s.cfg.rng, s.cfg.psd, s.cfg.cdma, 1'b0};
      `UCT_A_FRAME: r = {8'h00, s.cfg.act, s.cfg.cpm, s.cfg.spi};
      `UCT_A_SEED:  r = {17'h0, s.cfg.seed};
      `UCT_A_RATIO: r = {s.cfg.n, s.cfg.m};
      `UCT_A_BURST:
        r = {11'h0, s.cfg.fec, 5'h00, s.cfg.mod, 4'h0, s.cfg.uc};
      `UCT_A_STAT:
        r = {16'h0, s.cc, 4'h0, s.err_mode, s.err_burst,
             s.err_cdma, s.st != ST_IDLE};
      default: r = 32'h0;
    endcase
    return r;
  endfunction : reg_rd

  logic       acc;
  logic       go;
  logic [8:0] tb;

  // next-state logic: bus slave, start check, byte walk
  always_comb begin
    st_d = st_q;
    go   = 1'b0;
    tb   = tlv_byte(st_q.idx, st_q.sent, st_q.ts, st_q.cc, st_q.b5);
    st_d.rdy = 1'b1;
    // data phase of a write; the status word is read-only
    if (st_q.a_wr) begin
      st_d.a_wr = 1'b0;
      case (st_q.a_addr)
        `UCT_A_CTRL: begin
          st_d.cfg.cdma = hwdata[`UCT_F_CDMA];
          st_d.cfg.psd  = hwdata[`UCT_F_PSD];
          st_d.cfg.rng  = hwdata[`UCT_F_RNG];
          go            = hwdata[`UCT_F_GO];
        end
        `UCT_A_FRAME: begin
          st_d.cfg.spi = hwdata[7:0];
          st_d.cfg.cpm = hwdata[15:8];
          st_d.cfg.act = hwdata[23:16];
        end
        `UCT_A_SEED:  st_d.cfg.seed = hwdata[14:0];
        `UCT_A_RATIO: begin
          st_d.cfg.m = hwdata[15:0];
          st_d.cfg.n = hwdata[31:16];
        end
        `UCT_A_BURST: begin
          st_d.cfg.uc  = hwdata[3:0];
          st_d.cfg.mod = hwdata[10:8];
          st_d.cfg.fec = hwdata[20:16];
        end
        default: ;
      endcase
    end
    // message state machine
    case (st_q.st)
      ST_IDLE: begin
        // a start while busy is dropped, so only idle looks at go
        if (go) begin
          st_d.err_cdma  = cdma_bad(st_d.cfg);
          st_d.err_burst = burst_bad(st_d.cfg);
          st_d.err_mode  = mode_bad(st_d.cfg);
          if (!(st_d.err_cdma || st_d.err_burst || st_d.err_mode)) begin
            // snapshot alone never counts as a change
            if (st_q.sent_any && (st_d.cfg != st_q.sent))
              st_d.cc = st_q.cc + 8'h01;
            st_d.sent     = st_d.cfg;
            st_d.sent_any = 1'b1;
            st_d.ts       = ts_snap;
            st_d.b5       = need5(st_d.cfg);
            st_d.idx      = 6'h00;
            st_d.st       = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        // skipped bytes cost one idle cycle each, kept simple
        if (!st_q.tx_valid || tx_ready) begin
          st_d.tx_valid = tb[8];
          if (tb[8])
            st_d.tx_data = tb[7:0];
          st_d.tx_last = st_q.idx == `UCT_LAST;
          st_d.idx     = st_q.idx + 6'h01;
          if (st_q.idx == `UCT_LAST)
            st_d.st = ST_FIN;
        end
      end
      ST_FIN: begin
        if (tx_ready) begin
          st_d.tx_valid = 1'b0;
          st_d.tx_last  = 1'b0;
          st_d.st       = ST_IDLE;
        end
      end
      default: st_d.st = ST_IDLE;
    endcase
    // address phase; reads see this cycle's write already applied
    if (acc) begin
      st_d.a_wr   = hwrite;
      st_d.a_addr = haddr[7:0];
      if (!hwrite)
        st_d.rdata = (|haddr[31:8]) ? 32'h0 : reg_rd(haddr[7:0], st_d);
    end
  end

  // only whole-word transfers are taken; the rest answer okay quietly
  assign acc = hsel && hready && htrans[1] && (hsize == 3'b010)
               && !(hwrite && (|haddr[31:8]));

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q        <= '0;
      st_q.st     <= ST_IDLE;
      st_q.cc     <= `UCT_CC_RST;
      st_q.rdy    <= 1'b1;
      st_q.cfg.psd <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs come straight from the state flops
  assign hrdata    = st_q.rdata;
  assign hreadyout = st_q.rdy;
  assign hresp     = st_q.err_mode & 1'b0;
  assign tx_data   = st_q.tx_data;
  assign tx_valid  = st_q.tx_valid;
  assign tx_last   = st_q.tx_last;

  // checks on what leaves the sender
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_spi_range: assert property (
    (st_q.st != ST_IDLE && st_q.sent.cdma) |->
      st_q.sent.spi inside {[8'd1:8'd32]})
    else $error("spreading intervals out of range");
  a_cpm_range: assert property (
    (st_q.st != ST_IDLE && st_q.sent.cdma) |->
      st_q.sent.cpm inside {[8'd2:8'd32]})
    else $error("codes per mini-slot out of range");
  a_act_multiple: assert property (
    (st_q.st != ST_IDLE && st_q.sent.cdma) |->
      st_q.sent.act inside {[8'd64:8'd128]}
      && (st_q.sent.act % st_q.sent.cpm) == 8'h00)
    else $error("active codes illegal");
  a_cdma_omit: assert property (
    (st_q.st == ST_SEND && !st_q.sent.cdma
     && st_q.idx inside {[6'd4:6'd35]}
     && (!tx_valid || tx_ready)) |=> !tx_valid)
    else $error("code-division tlv sent with mode off");
  a_seed_pad: assert property (
    (tx_valid && st_q.idx == 6'd17) |-> tx_data[0] == 1'b0)
    else $error("seed not left-justified");
  a_snap_fresh: assert property (
    (st_q.st == ST_IDLE ##1 st_q.st == ST_SEND) |->
      st_q.ts == $past(ts_snap))
    else $error("snapshot not taken at start");
  a_count_hold: assert property (
    (st_q.st == ST_IDLE && st_d.st == ST_SEND
     && st_d.cfg == st_q.sent) |=> st_q.cc == $past(st_q.cc))
    else $error("change count moved without a change");
  a_burst_len: assert property (
    (tx_valid && st_q.idx == 6'd44) |-> tx_data == 8'h07)
    else $error("descriptor length wrong");
  a_code_nibble: assert property (
    (tx_valid && st_q.idx == 6'd45) |-> tx_data[7:4] == 4'h0)
    else $error("usage code high nibble set");
  a_type4_codes: assert property (
    (tx_valid && st_q.idx == 6'd43 && tx_data == 8'h04) |->
      st_q.sent.uc inside {[4'd1:4'd6]} && st_q.sent.mod <= 3'd2)
    else $error("type 4 used outside its codes");
  a_type_choice: assert property (
    (tx_valid && st_q.idx == 6'd43) |->
      ((st_q.sent.uc inside {4'd5, 4'd6}) ? tx_data == 8'h04 :
       (st_q.sent.uc inside {[4'd9:4'd11]} || st_q.sent.fec > 5'd10)
         ? tx_data == 8'h05 : 1'b1))
    else $error("descriptor type wrong for usage code");

  // byte order spots that the stream checks rely on, and the change count step
  a_mode_value: assert property (
    (tx_valid && st_q.idx == 6'd4) |->
      tx_data == (st_q.sent.cdma ? 8'h01 : 8'h02))
    else $error("mode value wrong");
  a_ratio_msb: assert property (
    (tx_valid && st_q.idx == 6'd20) |->
      tx_data == st_q.sent.m[15:8])
    else $error("ratio numerator not msb first");
  a_snap_len: assert property (
    (tx_valid && st_q.idx == 6'd27) |->
      tx_data == 8'h09)
    else $error("snapshot length wrong");
  a_count_step: assert property (
    (st_q.st == ST_IDLE && st_d.st == ST_SEND && st_q.sent_any
     && st_d.cfg != st_q.sent) |=> st_q.cc == $past(st_q.cc) + 8'h01)
    else $error("change count did not step on a change");

  // main scenarios
  c_send_cdma: cover property (st_q.st == ST_SEND && st_q.sent.cdma);
  c_send_tdma: cover property (st_q.st == ST_SEND && !st_q.sent.cdma);
  c_refused:   cover property ($rose(st_q.err_burst));
  c_count_up:  cover property (st_q.cc != $past(st_q.cc));
endmodule : uct_host

// ### rtl/uct_params.svh
// uct_params.svh: register map, field places and tlv codes of the sender
`ifndef UCT_PARAMS_SVH
`define UCT_PARAMS_SVH
// register byte offsets
`define UCT_A_CTRL  8'h00
`define UCT_A_FRAME 8'h04
`define UCT_A_SEED  8'h08
`define UCT_A_RATIO 8'h0c
`define UCT_A_BURST 8'h10
`define UCT_A_STAT  8'h14
// control field places
`define UCT_F_GO    0
`define UCT_F_CDMA  1
`define UCT_F_PSD   3:2
`define UCT_F_RNG   5:4
// channel tlv codes and lengths
`define UCT_T_MODE  8'h07
`define UCT_T_SPI   8'h08
`define UCT_T_CPM   8'h09
`define UCT_T_ACT   8'h0a
`define UCT_T_SEED  8'h0b
`define UCT_T_NUM   8'h0c
`define UCT_T_DEN   8'h0d
`define UCT_T_SNAP  8'h0e
`define UCT_T_PSD   8'h0f
`define UCT_T_RNG   8'h10
`define UCT_T_BD4   8'h04
`define UCT_T_BD5   8'h05
`define UCT_A_MOD   8'h01
`define UCT_A_FEC   8'h05
`define UCT_LEN1    8'h01
`define UCT_LEN2    8'h02
`define UCT_LEN9    8'h09
`define UCT_BD_LEN  8'h07
`define UCT_ON      8'h01
`define UCT_OFF     8'h02
// legal ranges
`define UCT_SPI_MIN 8'h01
`define UCT_CPM_MIN 8'h02
`define UCT_CX_MAX  8'h20
`define UCT_ACT_MIN 8'h40
`define UCT_ACT_MAX 8'h80
`define UCT_FEC4    5'h0a
`define UCT_FEC_MAX 5'h10
`define UCT_MOD4    3'h2
`define UCT_MOD_MAX 3'h6
// byte walk
`define UCT_CX_LO   6'h04
`define UCT_CX_HI   6'h23
`define UCT_SNAP0   6'h1b
`define UCT_LAST    6'h32
`define UCT_CC_RST  8'h00
`endif

// ### rtl/uct_pkg.sv
// uct_pkg.sv: state types of the channel tlv sender
package uct_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_FIN  = 2'b11
  } uct_state_e;

  typedef struct packed {
    logic        cdma;
    logic [1:0]  psd;
    logic [1:0]  rng;
    logic [7:0]  spi;
    logic [7:0]  cpm;
    logic [7:0]  act;
    logic [14:0] seed;
    logic [15:0] m;
    logic [15:0] n;
    logic [3:0]  uc;
    logic [2:0]  mod;
    logic [4:0]  fec;
  } uct_cfg_s;

  typedef struct packed {
    uct_state_e  st;
    uct_cfg_s    cfg;
    uct_cfg_s    sent;
    logic        sent_any;
    logic [71:0] ts;
    logic [7:0]  cc;
    logic        b5;
    logic [5:0]  idx;
    logic        tx_valid;
    logic        tx_last;
    logic [7:0]  tx_data;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
    logic        rdy;
    logic        err_cdma;
    logic        err_burst;
    logic        err_mode;
  } uct_st_s;
endpackage : uct_pkg
